// file: rtl/dtx_pkg.sv
// Purpose: Shared constants and types of the data transfer executor
// Assumes: Sixteen-bit words, eight general registers
// Notes: Flag word layout is the processor's fixed one
package dtx_pkg;

	// General register indices
	localparam logic [2:0] REG_ACC = 3'h0;
	localparam logic [2:0] REG_PIDX = 3'h2;
	localparam logic [2:0] REG_TBASE = 3'h3;
	localparam logic [2:0] REG_STK = 3'h4;

	// Register port map
	localparam logic [3:0] RA_DSEG = 4'h8;
	localparam logic [3:0] RA_ESEG = 4'h9;
	localparam logic [3:0] RA_FLAGS = 4'hA;
	localparam logic [3:0] RA_STATUS = 4'hB;

	// Flag positions in the flag word and in the high accumulator byte
	localparam int FL_CARRY = 0;
	localparam int FL_PAR = 2;
	localparam int FL_AUX = 4;
	localparam int FL_ZERO = 6;
	localparam int FL_SIGN = 7;
	localparam int FL_TRAP = 8;
	localparam int FL_IEN = 9;
	localparam int FL_DIR = 10;
	localparam int FL_OVF = 11;

	// Defined bits, and the value that unused bits always hold
	localparam logic [15:0] FL_DEFINED = 16'h0FD5;
	localparam logic [15:0] FL_FIXED = 16'hF002;
	localparam logic [15:0] FL_RESET = 16'hF002;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0] HIGH_FILL = 8'h00;

	// Stack and pointer steps in bytes
	localparam logic [15:0] STACK_STEP = 16'h0002;
	localparam logic [15:0] PTR_STEP = 16'h0002;

	// Segment codes on the bus
	localparam logic [1:0] SEG_EXTRA = 2'h0;
	localparam logic [1:0] SEG_SS = 2'h1;
	localparam logic [1:0] SEG_NONE = 2'h2;
	localparam logic [1:0] SEG_DATA = 2'h3;

	typedef enum logic [3:0] {
		OP_COPY, OP_PUSH, OP_POP, OP_SWAP, OP_LOOKUP, OP_IN, OP_OUT,
		OP_OFFSET, OP_FARD, OP_FARE, OP_FL2H, OP_H2FL, OP_FSAVE, OP_FREST
	} dtx_op_t;

	typedef enum logic [1:0] {
		ST_IDLE, ST_READ, ST_READ2, ST_WRITE
	} dtx_st_t;

endpackage

// file: rtl/dtx_exec.sv
// Purpose: Executes the data transfer instruction group of a 16-bit core
// Assumes: Operand offsets arrive already computed; bus answers with a one-cycle ack
// Notes: Register file and flags live here; the register port reaches them
//
// Summary of operation
// RQ1: Copy moves one byte or word from source to destination, source unchanged.
// RQ2: Stack store lowers stack_ptr by two, then writes the word there.
// RQ3: Stack load reads word at stack_ptr into destination, then raises it by two.
// RQ4: Swap exchanges two operands; with bus hold it is an indivisible test-and-set.
// RQ5: Table lookup fetches byte at table base plus low accumulator, replaces it.
// RQ6: Port read loads low accumulator byte or the whole accumulator word.
// RQ7: Port number is immediate byte (0-255) or port index register (0-65535).
// RQ8: Port write sends low accumulator byte or whole accumulator word.
// RQ9: Offset load writes the operand offset to a register, flags untouched.
// RQ10: Far pointer load: offset word to register, segment word to data segment.
// RQ11: Far pointer load: offset word to register, segment word to extra segment.
// RQ12: Programs give offset and pointer loads a memory source, word register destination.
// RQ13: Flags to high accumulator: sign, zero, aux, parity, carry at 7,6,4,2,0.
// RQ14: Bits 5, 3, 1 of that byte are don't-care; flags stay unchanged.
// RQ15: High accumulator to flags loads sign, zero, aux, parity, carry from 7,6,4,2,0.
// RQ16: That store leaves overflow, direction, interrupt-enable and trap flags alone.
// RQ17: Flag save lowers stack_ptr by two, writes flag word, flags unchanged.
// RQ18: Flag restore loads defined bits from stack top, then raises stack_ptr by two.
// RQ19: Trap flag is bit 8 of the image; only a flag restore changes it.
// RQ20: Flag word follows the fixed layout; unused bits hold fixed values.
`timescale 1ns/100ps

module dtx_exec (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Command from the core
	input wire logic cmd_valid,
	input wire dtx_pkg::dtx_op_t cmd_op,
	input wire logic cmd_word,
	input wire logic [2:0] cmd_dreg,
	input wire logic [2:0] cmd_sreg,
	input wire logic cmd_dst_mem,
	input wire logic cmd_src_mem,
	input wire logic cmd_src_imm,
	input wire logic cmd_port_idx,
	input wire logic cmd_lock,
	input wire logic [15:0] cmd_addr,
	input wire logic [15:0] cmd_imm,
	output logic cmd_busy,
	output logic cmd_done,
	// System bus master
	output logic bus_req,
	output logic bus_we,
	output logic bus_io,
	output logic bus_word,
	output logic bus_lock,
	output logic [1:0] bus_seg,
	output logic [15:0] bus_addr,
	output logic [15:0] bus_wdata,
	input wire logic bus_ack,
	input wire logic [15:0] bus_rdata,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata
);

	typedef struct packed {
		dtx_pkg::dtx_st_t st;
		dtx_pkg::dtx_op_t op;
		logic wd;
		logic [2:0] dreg;
		logic [15:0] tmp;
		logic [7:0][15:0] gr;
		logic [15:0] dseg;
		logic [15:0] eseg;
		logic [15:0] fl;
		logic busy;
		logic done;
		logic req;
		logic we;
		logic io;
		logic bword;
		logic lock;
		logic [1:0] seg;
		logic [15:0] baddr;
		logic [15:0] bwdata;
		logic [15:0] rdata;
	} dtx_state_t;

	dtx_state_t q, n;

	// Byte registers 4..7 are the high halves of registers 0..3
	function automatic logic [15:0] rget(input logic [7:0][15:0] gr, input logic [2:0] idx,
		input logic wd);
		logic [15:0] w;
		w = gr[{1'b0, idx[1:0]}];
		if (wd) begin
			rget = gr[idx];
		end else if (idx[2]) begin
			rget = {8'h00, w[15:8]};
		end else begin
			rget = {8'h00, w[7:0]};
		end
	endfunction

	function automatic logic [7:0][15:0] rput(input logic [7:0][15:0] gr,
		input logic [2:0] idx, input logic wd, input logic [15:0] v);
		logic [7:0][15:0] g;
		g = gr;
		if (wd) begin
			g[idx] = v;
		end else if (idx[2]) begin
			g[{1'b0, idx[1:0]}][15:8] = v[7:0];
		end else begin
			g[{1'b0, idx[1:0]}][7:0] = v[7:0];
		end
		rput = g;
	endfunction

	logic [15:0] src_val;
	logic [15:0] stk_val;
	logic [7:0] acc_high;
	logic [15:0] port_num;

	always_comb begin
		src_val = cmd_src_imm ? cmd_imm : rget(q.gr, cmd_sreg, cmd_word);
		stk_val = q.gr[dtx_pkg::REG_STK];
		acc_high = q.gr[dtx_pkg::REG_ACC][15:8];
		// RQ7 port number source
		port_num = cmd_port_idx ? q.gr[dtx_pkg::REG_PIDX] : {8'h00, cmd_imm[7:0]};
	end

	always_comb begin
		n = q;
		n.done = 1'b0;
		n.rdata = dtx_pkg::WORD_RESET;
		if (reg_rd) begin
			if (!reg_addr[3]) begin
				n.rdata = q.gr[reg_addr[2:0]];
			end else if (reg_addr == dtx_pkg::RA_DSEG) begin
				n.rdata = q.dseg;
			end else if (reg_addr == dtx_pkg::RA_ESEG) begin
				n.rdata = q.eseg;
			end else if (reg_addr == dtx_pkg::RA_FLAGS) begin
				n.rdata = q.fl;
			end else if (reg_addr == dtx_pkg::RA_STATUS) begin
				n.rdata = {15'h0000, q.busy};
			end
		end
		// Flags are not writable here so the trap flag has a single path in
		if (reg_wr) begin
			if (!reg_addr[3]) begin
				n.gr[reg_addr[2:0]] = reg_wdata;
			end else if (reg_addr == dtx_pkg::RA_DSEG) begin
				n.dseg = reg_wdata;
			end else if (reg_addr == dtx_pkg::RA_ESEG) begin
				n.eseg = reg_wdata;
			end
		end
		case (q.st)
			dtx_pkg::ST_IDLE: begin
				if (cmd_valid) begin
					n.op = cmd_op;
					n.wd = cmd_word;
					n.dreg = cmd_dreg;
					n.busy = 1'b1;
					n.bword = cmd_word;
					n.io = 1'b0;
					n.lock = 1'b0;
					n.seg = dtx_pkg::SEG_DATA;
					n.baddr = cmd_addr;
					n.we = 1'b0;
					n.req = 1'b1;
					n.st = dtx_pkg::ST_READ;
					case (cmd_op)
						dtx_pkg::OP_COPY: begin
							// RQ1 copy operand
							if (cmd_dst_mem) begin
								n.we = 1'b1;
								n.bwdata = src_val;
								n.st = dtx_pkg::ST_WRITE;
							end else if (!cmd_src_mem) begin
								n.gr = rput(n.gr, cmd_dreg, cmd_word, src_val);
								n.req = 1'b0;
								n.st = dtx_pkg::ST_IDLE;
							end
						end
						dtx_pkg::OP_PUSH, dtx_pkg::OP_FSAVE: begin
							// RQ2 RQ17 lower then store
							n.gr[dtx_pkg::REG_STK] = stk_val - dtx_pkg::STACK_STEP;
							n.baddr = stk_val - dtx_pkg::STACK_STEP;
							n.seg = dtx_pkg::SEG_SS;
							n.bword = 1'b1;
							n.we = 1'b1;
							n.bwdata = (cmd_op == dtx_pkg::OP_FSAVE) ? q.fl
								: (cmd_src_imm ? cmd_imm : q.gr[cmd_sreg]);
							n.st = dtx_pkg::ST_WRITE;
						end
						dtx_pkg::OP_POP, dtx_pkg::OP_FREST: begin
							// RQ3 RQ18 read stack top first
							n.baddr = stk_val;
							n.seg = dtx_pkg::SEG_SS;
							n.bword = 1'b1;
						end
						dtx_pkg::OP_SWAP: begin
							// RQ4 swap operands, held bus when locked
							if (cmd_dst_mem) begin
								n.lock = cmd_lock;
							end else begin
								n.gr = rput(n.gr, cmd_dreg, cmd_word,
									rget(q.gr, cmd_sreg, cmd_word));
								n.gr = rput(n.gr, cmd_sreg, cmd_word,
									rget(q.gr, cmd_dreg, cmd_word));
								n.req = 1'b0;
								n.st = dtx_pkg::ST_IDLE;
							end
						end
						dtx_pkg::OP_LOOKUP: begin
							// RQ5 index from zero, unsigned
							n.baddr = q.gr[dtx_pkg::REG_TBASE]
								+ {8'h00, q.gr[dtx_pkg::REG_ACC][7:0]};
							n.bword = 1'b0;
						end
						dtx_pkg::OP_IN: begin
							// RQ6 RQ7 port read
							n.io = 1'b1;
							n.seg = dtx_pkg::SEG_NONE;
							n.baddr = port_num;
						end
						dtx_pkg::OP_OUT: begin
							// RQ8 RQ7 port write
							n.io = 1'b1;
							n.we = 1'b1;
							n.seg = dtx_pkg::SEG_NONE;
							n.baddr = port_num;
							n.bwdata = rget(q.gr, dtx_pkg::REG_ACC, cmd_word);
							n.st = dtx_pkg::ST_WRITE;
						end
						dtx_pkg::OP_OFFSET: begin
							// RQ9 offset only, flags kept
							n.gr[cmd_dreg] = cmd_addr;
							n.req = 1'b0;
							n.st = dtx_pkg::ST_IDLE;
						end
						dtx_pkg::OP_FARD, dtx_pkg::OP_FARE: begin
							// RQ10 RQ11 offset word first
							n.bword = 1'b1;
						end
						dtx_pkg::OP_FL2H: begin
							// RQ13 RQ14 flag copy, spare bits filled
							n.gr[dtx_pkg::REG_ACC][15:8] = fl_high_img(q.fl);
							n.req = 1'b0;
							n.st = dtx_pkg::ST_IDLE;
						end
						dtx_pkg::OP_H2FL: begin
							// RQ15 RQ16 low five flags only
							n.fl[dtx_pkg::FL_SIGN] = acc_high[dtx_pkg::FL_SIGN];
							n.fl[dtx_pkg::FL_ZERO] = acc_high[dtx_pkg::FL_ZERO];
							n.fl[dtx_pkg::FL_AUX] = acc_high[dtx_pkg::FL_AUX];
							n.fl[dtx_pkg::FL_PAR] = acc_high[dtx_pkg::FL_PAR];
							n.fl[dtx_pkg::FL_CARRY] = acc_high[dtx_pkg::FL_CARRY];
							n.req = 1'b0;
							n.st = dtx_pkg::ST_IDLE;
						end
						default: begin
							n.req = 1'b0;
							n.st = dtx_pkg::ST_IDLE;
						end
					endcase
					if (n.st == dtx_pkg::ST_IDLE) begin
						n.busy = 1'b0;
						n.done = 1'b1;
					end
				end
			end
			dtx_pkg::ST_READ: begin
				if (bus_ack) begin
					n.busy = 1'b0;
					n.done = 1'b1;
					n.req = 1'b0;
					n.st = dtx_pkg::ST_IDLE;
					case (q.op)
						dtx_pkg::OP_POP: begin
							// RQ3 raise after the read
							n.gr[dtx_pkg::REG_STK] = stk_val + dtx_pkg::STACK_STEP;
							n.gr[q.dreg] = bus_rdata;
						end
						dtx_pkg::OP_FREST: begin
							// RQ18 RQ19 RQ20 restore with fixed layout
							n.fl = (bus_rdata & dtx_pkg::FL_DEFINED) | dtx_pkg::FL_FIXED;
							n.gr[dtx_pkg::REG_STK] = stk_val + dtx_pkg::STACK_STEP;
						end
						dtx_pkg::OP_SWAP: begin
							// RQ4 old register value goes back to memory
							n.gr = rput(q.gr, q.dreg, q.wd, bus_rdata);
							n.bwdata = rget(q.gr, q.dreg, q.wd);
							n.we = 1'b1;
							n.req = 1'b1;
							n.busy = 1'b1;
							n.done = 1'b0;
							n.st = dtx_pkg::ST_WRITE;
						end
						dtx_pkg::OP_LOOKUP: begin
							n.gr[dtx_pkg::REG_ACC][7:0] = bus_rdata[7:0];
						end
						dtx_pkg::OP_IN: begin
							n.gr = rput(q.gr, dtx_pkg::REG_ACC, q.wd, bus_rdata);
						end
						dtx_pkg::OP_FARD, dtx_pkg::OP_FARE: begin
							n.tmp = bus_rdata;
							n.baddr = q.baddr + dtx_pkg::PTR_STEP;
							n.req = 1'b1;
							n.busy = 1'b1;
							n.done = 1'b0;
							n.st = dtx_pkg::ST_READ2;
						end
						default: begin
							// RQ1 memory to register copy
							n.gr = rput(q.gr, q.dreg, q.wd, bus_rdata);
						end
					endcase
				end
			end
			dtx_pkg::ST_READ2: begin
				if (bus_ack) begin
					// RQ10 RQ11 segment word second
					n.gr[q.dreg] = q.tmp;
					if (q.op == dtx_pkg::OP_FARD) begin
						n.dseg = bus_rdata;
					end else begin
						n.eseg = bus_rdata;
					end
					n.busy = 1'b0;
					n.done = 1'b1;
					n.req = 1'b0;
					n.st = dtx_pkg::ST_IDLE;
				end
			end
			dtx_pkg::ST_WRITE: begin
				if (bus_ack) begin
					n.busy = 1'b0;
					n.done = 1'b1;
					n.req = 1'b0;
					n.we = 1'b0;
					n.lock = 1'b0;
					n.st = dtx_pkg::ST_IDLE;
				end
			end
			default: begin
				n.st = dtx_pkg::ST_IDLE;
			end
		endcase
	end

	function automatic logic [7:0] fl_high_img(input logic [15:0] f);
		logic [7:0] b;
		b = dtx_pkg::HIGH_FILL;
		b[dtx_pkg::FL_SIGN] = f[dtx_pkg::FL_SIGN];
		b[dtx_pkg::FL_ZERO] = f[dtx_pkg::FL_ZERO];
		b[dtx_pkg::FL_AUX] = f[dtx_pkg::FL_AUX];
		b[dtx_pkg::FL_PAR] = f[dtx_pkg::FL_PAR];
		b[dtx_pkg::FL_CARRY] = f[dtx_pkg::FL_CARRY];
		fl_high_img = b;
	endfunction

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.fl <= dtx_pkg::FL_RESET;
		end else begin
			q <= n;
		end
	end

	assign cmd_busy = q.busy;
	assign cmd_done = q.done;
	assign bus_req = q.req;
	assign bus_we = q.we;
	assign bus_io = q.io;
	assign bus_word = q.bword;
	assign bus_lock = q.lock;
	assign bus_seg = q.seg;
	assign bus_addr = q.baddr;
	assign bus_wdata = q.bwdata;
	assign reg_rdata = q.rdata;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	logic start;
	assign start = (q.st == dtx_pkg::ST_IDLE) && cmd_valid && !reg_wr;

	AST_PUSH_STK: assert property ( // RQ2
		start && cmd_op == dtx_pkg::OP_PUSH |=> q.gr[dtx_pkg::REG_STK]
			== $past(q.gr[dtx_pkg::REG_STK]) - dtx_pkg::STACK_STEP
			&& bus_we && bus_addr == q.gr[dtx_pkg::REG_STK])
		else $error("push did not lower stack pointer before store");
	AST_POP_STK: assert property ( // RQ3
		q.st == dtx_pkg::ST_READ && q.op == dtx_pkg::OP_POP && bus_ack && !reg_wr
			&& q.dreg != dtx_pkg::REG_STK |=> q.gr[dtx_pkg::REG_STK]
			== $past(q.gr[dtx_pkg::REG_STK]) + dtx_pkg::STACK_STEP)
		else $error("pop did not raise stack pointer by two");
	AST_LOOKUP_ADDR: assert property ( // RQ5
		q.st == dtx_pkg::ST_READ && q.op == dtx_pkg::OP_LOOKUP |-> !bus_word
			&& bus_addr == q.gr[dtx_pkg::REG_TBASE] + {8'h00, q.gr[dtx_pkg::REG_ACC][7:0]})
		else $error("lookup address wrong");
	AST_IMM_PORT: assert property ( // RQ7
		start && cmd_op == dtx_pkg::OP_IN && !cmd_port_idx |=> bus_io && bus_req
			&& bus_addr[15:8] == 8'h00)
		else $error("immediate port beyond 255");
	AST_OFFSET_FLAGS: assert property ( // RQ9
		start && cmd_op == dtx_pkg::OP_OFFSET |=> $stable(q.fl)
			&& q.gr[$past(cmd_dreg)] == $past(cmd_addr))
		else $error("offset load wrong or flags moved");
	AST_FL2H: assert property ( // RQ13
		start && cmd_op == dtx_pkg::OP_FL2H |=> $stable(q.fl)
			&& acc_high[dtx_pkg::FL_SIGN] == q.fl[dtx_pkg::FL_SIGN]
			&& acc_high[dtx_pkg::FL_CARRY] == q.fl[dtx_pkg::FL_CARRY])
		else $error("flag copy to high byte wrong");
	AST_H2FL_KEEP: assert property ( // RQ16
		start && cmd_op == dtx_pkg::OP_H2FL |=> q.fl[dtx_pkg::FL_OVF:dtx_pkg::FL_TRAP]
			== $past(q.fl[dtx_pkg::FL_OVF:dtx_pkg::FL_TRAP])
			&& q.fl[dtx_pkg::FL_ZERO] == $past(acc_high[dtx_pkg::FL_ZERO]))
		else $error("high byte store touched upper flags");
	AST_TRAP_ONLY_REST: assert property ( // RQ19
		$changed(q.fl[dtx_pkg::FL_TRAP]) |-> $past(q.st == dtx_pkg::ST_READ
			&& q.op == dtx_pkg::OP_FREST && bus_ack))
		else $error("trap flag changed outside restore");
	AST_SWAP_LOCK: assert property ( // RQ4
		q.st == dtx_pkg::ST_READ && q.op == dtx_pkg::OP_SWAP && bus_lock && bus_ack
			|=> bus_lock && bus_we && bus_req)
		else $error("locked swap released bus early");

	COV_FSAVE: cover property (start && cmd_op == dtx_pkg::OP_FSAVE ##[1:20] cmd_done);
	COV_FREST: cover property (q.op == dtx_pkg::OP_FREST && bus_ack ##1 cmd_done);
	COV_FAR: cover property (q.st == dtx_pkg::ST_READ2 && bus_ack);
	COV_SWAP_LOCK: cover property (q.op == dtx_pkg::OP_SWAP && bus_lock && bus_we && bus_ack);

endmodule

// file: testbench/dtx_bus_model.sv
// Purpose: Memory and port space that answers the executor's system bus
// Assumes: One transfer at a time; lat sets the wait cycles before each ack
// Notes: Port space sits above memory in one array, indexed by bus_io
`timescale 1ns/100ps

module dtx_bus_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// System bus
	input wire logic bus_req,
	input wire logic bus_we,
	input wire logic bus_io,
	input wire logic bus_word,
	input wire logic bus_lock,
	input wire logic [1:0] bus_seg,
	input wire logic [15:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	output logic bus_ack,
	output logic [15:0] bus_rdata,
	// Answer delay
	input wire logic [3:0] lat
);
	logic [7:0] mem [0:131071];
	logic [3:0] wait_q;
	logic [16:0] lo_a;
	logic [16:0] hi_a;
	logic [15:0] last_addr;
	logic [1:0] last_seg;
	logic last_io;
	int xfers;
	int locked;

	assign lo_a = {bus_io, bus_addr};
	assign hi_a = {bus_io, bus_addr + 16'h0001};

	// Read data toggles outside an ack, so a late sample never sees good data
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			bus_ack <= 1'b0;
			bus_rdata <= 16'h5A5A;
			wait_q <= 4'h0;
		end else if (bus_ack || !bus_req) begin
			bus_ack <= 1'b0;
			bus_rdata <= ~bus_rdata;
			wait_q <= 4'h0;
		end else if (wait_q < lat) begin
			wait_q <= wait_q + 4'h1;
			bus_rdata <= ~bus_rdata;
		end else begin
			bus_ack <= 1'b1;
			bus_rdata <= {mem[hi_a], mem[lo_a]};
			xfers <= xfers + 1;
			locked <= locked + (bus_lock ? 1 : 0);
			last_addr <= bus_addr;
			last_seg <= bus_seg;
			last_io <= bus_io;
			if (bus_we) begin
				mem[lo_a] <= bus_wdata[7:0];
				if (bus_word)
					mem[hi_a] <= bus_wdata[15:8];
			end
		end
	end
endmodule

// file: testbench/dtx_exec_tb.sv
// Purpose: Self-checking bench of the data transfer executor
// Assumes: Bus partner is dtx_bus_model; registers reached over the port
// Notes: Flags are set only through high-byte and stack restores
`timescale 1ns/100ps

module dtx_exec_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid, cmd_word, cmd_dst_mem, cmd_src_mem, cmd_src_imm, cmd_port_idx, cmd_lock;
	dtx_pkg::dtx_op_t cmd_op;
	logic [2:0] cmd_dreg, cmd_sreg;
	logic [15:0] cmd_addr, cmd_imm, bus_addr, bus_wdata, bus_rdata, reg_wdata, reg_rdata, rv;
	logic cmd_busy, cmd_done, bus_req, bus_we, bus_io, bus_word, bus_lock, bus_ack;
	logic [1:0] bus_seg;
	logic [3:0] reg_addr, lat;
	logic reg_wr, reg_rd;
	int fails = 0;
	int comparisons = 0;
	int x0, l0;

	dtx_exec i_dtx_exec (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_word(cmd_word), .cmd_dreg(cmd_dreg), .cmd_sreg(cmd_sreg),
		.cmd_dst_mem(cmd_dst_mem), .cmd_src_mem(cmd_src_mem), .cmd_src_imm(cmd_src_imm),
		.cmd_port_idx(cmd_port_idx), .cmd_lock(cmd_lock), .cmd_addr(cmd_addr),
		.cmd_imm(cmd_imm), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .bus_req(bus_req),
		.bus_we(bus_we), .bus_io(bus_io), .bus_word(bus_word), .bus_lock(bus_lock),
		.bus_seg(bus_seg), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	dtx_bus_model i_dtx_bus_model (.clock(clock), .rst(rst), .bus_req(bus_req),
		.bus_we(bus_we), .bus_io(bus_io), .bus_word(bus_word), .bus_lock(bus_lock),
		.bus_seg(bus_seg), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata), .lat(lat));

	always #50 clock = ~clock;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic setw(input logic [16:0] a, input logic [15:0] d);
		i_dtx_bus_model.mem[a] = d[7:0];
		i_dtx_bus_model.mem[a + 17'h00001] = d[15:8];
	endtask

	function automatic logic [15:0] mw(input logic [16:0] a);
		return {i_dtx_bus_model.mem[a + 17'h00001], i_dtx_bus_model.mem[a]};
	endfunction

	task automatic rw(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		rd(a);
		check(rv, e, "register read");
	endtask

	// Mode bits m: dst_mem, src_mem, src_imm, port_idx, lock
	task automatic run(input dtx_pkg::dtx_op_t op, input logic w, input logic [2:0] d,
		input logic [2:0] s, input logic [4:0] m, input logic [15:0] a, input logic [15:0] i);
		int n;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_word <= w;
		cmd_dreg <= d;
		cmd_sreg <= s;
		{cmd_dst_mem, cmd_src_mem, cmd_src_imm, cmd_port_idx, cmd_lock} <= m;
		cmd_addr <= a;
		cmd_imm <= i;
		@(posedge clock);
		cmd_valid <= 1'b0;
		n = 0;
		#1;
		while (cmd_done !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		check({15'h0000, cmd_done}, 16'h0001, "command done");
	endtask

	task automatic t_reset;
		rchk(4'hA, dtx_pkg::FL_RESET);
		rchk(4'hB, 16'h0000);
		rchk(4'hC, 16'h0000);
		rchk(4'h4, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_copy;
		rw(4'h1, 16'h1234);
		run(dtx_pkg::OP_COPY, 1'b1, 3'h5, 3'h1, 5'h00, 16'h0000, 16'h0000);
		rchk(4'h5, 16'h1234);
		rchk(4'h1, 16'h1234);
		rw(4'h0, 16'h1111);
		run(dtx_pkg::OP_COPY, 1'b0, 3'h4, 3'h0, 5'h04, 16'h0000, 16'h00AB);
		rchk(4'h0, 16'hAB11);
		run(dtx_pkg::OP_COPY, 1'b1, 3'h0, 3'h1, 5'h10, 16'h0100, 16'h0000);
		check(mw(17'h00100), 16'h1234, "copy to memory");
		setw(17'h00200, 16'h775A);
		run(dtx_pkg::OP_COPY, 1'b0, 3'h1, 3'h0, 5'h08, 16'h0200, 16'h0000);
		rchk(4'h1, 16'h125A);
		$display("test copy done");
	endtask

	task automatic t_stack;
		lat <= 4'h3;
		rw(4'h4, 16'h0100);
		rw(4'h3, 16'hBEEF);
		run(dtx_pkg::OP_PUSH, 1'b1, 3'h0, 3'h3, 5'h00, 16'h0000, 16'h0000);
		rchk(4'h4, 16'h00FE);
		check(mw(17'h000FE), 16'hBEEF, "pushed word");
		check({14'h0000, i_dtx_bus_model.last_seg}, {14'h0000, dtx_pkg::SEG_SS}, "seg");
		run(dtx_pkg::OP_PUSH, 1'b1, 3'h0, 3'h0, 5'h04, 16'h0000, 16'h7777);
		check(mw(17'h000FC), 16'h7777, "pushed imm");
		run(dtx_pkg::OP_POP, 1'b1, 3'h6, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'h6, 16'h7777);
		rchk(4'h4, 16'h00FE);
		run(dtx_pkg::OP_POP, 1'b1, 3'h7, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'h7, 16'hBEEF);
		rchk(4'h4, 16'h0100);
		$display("test stack done");
	endtask

	task automatic t_swap;
		lat <= 4'h1;
		rw(4'h5, 16'h1111);
		rw(4'h6, 16'h2222);
		run(dtx_pkg::OP_SWAP, 1'b1, 3'h5, 3'h6, 5'h00, 16'h0000, 16'h0000);
		rchk(4'h5, 16'h2222);
		rchk(4'h6, 16'h1111);
		setw(17'h00300, 16'hCAFE);
		x0 = i_dtx_bus_model.xfers;
		l0 = i_dtx_bus_model.locked;
		run(dtx_pkg::OP_SWAP, 1'b1, 3'h5, 3'h0, 5'h11, 16'h0300, 16'h0000);
		rchk(4'h5, 16'hCAFE);
		check(mw(17'h00300), 16'h2222, "swapped memory");
		check(16'(i_dtx_bus_model.locked - l0), 16'h0002, "locked transfers");
		check(16'(i_dtx_bus_model.xfers - x0), 16'h0002, "swap transfers");
		$display("test swap done");
	endtask

	task automatic t_lookup;
		lat <= 4'h2;
		rw(4'h3, 16'h0400);
		rw(4'h0, 16'h99FF);
		setw(17'h00400, 16'hEE11);
		setw(17'h004FE, 16'h33CC);
		run(dtx_pkg::OP_LOOKUP, 1'b0, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'h0, 16'h9933);
		check(i_dtx_bus_model.last_addr, 16'h04FF, "lookup address");
		rw(4'h0, 16'h9900);
		run(dtx_pkg::OP_LOOKUP, 1'b0, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'h0, 16'h9911);
		$display("test lookup done");
	endtask

	// The immediate port number of the first port read carries junk above bit 7 to prove it is ignored
	task automatic t_port;
		lat <= 4'h0;
		setw(17'h100FF, 16'h775C);
		rw(4'h0, 16'h1234);
		run(dtx_pkg::OP_IN, 1'b0, 3'h0, 3'h0, 5'h00, 16'h0000, 16'hAAFF);
		rchk(4'h0, 16'h125C);
		check(i_dtx_bus_model.last_addr, 16'h00FF, "port number");
		check({15'h0000, i_dtx_bus_model.last_io}, 16'h0001, "port cycle");
		rw(4'h2, 16'h8001);
		setw(17'h18001, 16'hA55A);
		run(dtx_pkg::OP_IN, 1'b1, 3'h0, 3'h0, 5'h02, 16'h0000, 16'h0000);
		rchk(4'h0, 16'hA55A);
		check(i_dtx_bus_model.last_addr, 16'h8001, "port index");
		setw(17'h10010, 16'h0000);
		run(dtx_pkg::OP_OUT, 1'b0, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0010);
		check(mw(17'h10010), 16'h005A, "byte out");
		rw(4'h2, 16'hFFFE);
		run(dtx_pkg::OP_OUT, 1'b1, 3'h0, 3'h0, 5'h02, 16'h0000, 16'h0000);
		check(mw(17'h1FFFE), 16'hA55A, "word out");
		$display("test port done");
	endtask

	task automatic t_flags;
		lat <= 4'h1;
		rw(4'h0, 16'hFF00);
		run(dtx_pkg::OP_H2FL, 1'b0, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'hA, 16'hF0D7);
		rw(4'h0, 16'h0000);
		run(dtx_pkg::OP_FL2H, 1'b0, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rd(4'h0);
		check(rv & 16'hD5FF, 16'hD500, "flag image in high byte");
		rchk(4'hA, 16'hF0D7);
		rw(4'h0, 16'h2A00);
		run(dtx_pkg::OP_H2FL, 1'b0, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'hA, 16'hF002);
		rw(4'h4, 16'h0200);
		setw(17'h00200, 16'hFFFF);
		run(dtx_pkg::OP_FREST, 1'b1, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'hA, 16'hFFD7);
		rchk(4'h4, 16'h0202);
		rw(4'h0, 16'h0000);
		run(dtx_pkg::OP_H2FL, 1'b0, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'hA, 16'hFF02);
		run(dtx_pkg::OP_FSAVE, 1'b1, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		check(mw(17'h00200), 16'hFF02, "saved flags");
		rchk(4'h4, 16'h0200);
		rchk(4'hA, 16'hFF02);
		setw(17'h00200, 16'h0100);
		run(dtx_pkg::OP_FREST, 1'b1, 3'h0, 3'h0, 5'h00, 16'h0000, 16'h0000);
		rchk(4'hA, 16'hF102);
		x0 = i_dtx_bus_model.xfers;
		run(dtx_pkg::OP_OFFSET, 1'b1, 3'h3, 3'h0, 5'h08, 16'h1234, 16'h0000);
		rchk(4'h3, 16'h1234);
		rchk(4'hA, 16'hF102);
		check(16'(i_dtx_bus_model.xfers - x0), 16'h0000, "offset load bus use");
		$display("test flags done");
	endtask

	task automatic t_far;
		lat <= 4'h2;
		setw(17'h00500, 16'h0ABC);
		setw(17'h00502, 16'h1000);
		run(dtx_pkg::OP_FARD, 1'b1, 3'h6, 3'h0, 5'h08, 16'h0500, 16'h0000);
		rchk(4'h6, 16'h0ABC);
		rchk(4'h8, 16'h1000);
		setw(17'h00504, 16'h0DEF);
		setw(17'h00506, 16'h2000);
		run(dtx_pkg::OP_FARE, 1'b1, 3'h7, 3'h0, 5'h08, 16'h0504, 16'h0000);
		rchk(4'h7, 16'h0DEF);
		rchk(4'h9, 16'h2000);
		rchk(4'h8, 16'h1000);
		$display("test pointer done");
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		stop_test;
	end

	initial begin
		{cmd_valid, cmd_word, cmd_dst_mem, cmd_src_mem, cmd_src_imm, cmd_port_idx} = 6'h00;
		cmd_lock = 1'b0;
		cmd_op = dtx_pkg::OP_COPY;
		{cmd_dreg, cmd_sreg} = 6'h00;
		{cmd_addr, cmd_imm, reg_wdata} = 48'h000000000000;
		{reg_addr, lat, reg_wr, reg_rd} = 10'h000;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_copy;
		t_stack;
		t_swap;
		t_lookup;
		t_port;
		t_flags;
		t_far;
		stop_test;
	end
endmodule
